// [sdcst_command_spacing_timer_bench.sv]
`timescale 1ns/1ps
// random and hand-picked command streams; gaps judged at the memory model
module sdcst_command_spacing_timer_bench;
  import sdcst_pkg::*;
  localparam int TCK = 32000;     // bench command clock in ps
  localparam int WRD = 10;        // write data length, design default
  localparam int LIM = 9000;      // bound on every wait, covers the lock wait
  logic i_sys_clk, i_rst, i_link_clk, i_cmd_valid, i_dll_reset, i_high_grade, i_page_2k;
  sdcst_cmd_e i_cmd, o_mem_cmd, m_cmd, p_cmd;
  logic [2:0] i_bank, o_mem_bank, m_bank, p_bank;
  logic o_cmd_ready, o_mem_strobe, o_mem_dll_reset, m_dll, p_dll;
  logic [15:0] m_count;
  logic [10:0] m_gap;
  logic [31:0] seed;              // random state
  int errors, checks;
  sdcst_top #(.TCK_PS(TCK)) u_dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .i_link_clk(i_link_clk), .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd), .i_bank(i_bank),
    .i_dll_reset(i_dll_reset), .i_high_grade(i_high_grade), .i_page_2k(i_page_2k),
    .o_cmd_ready(o_cmd_ready), .o_mem_cmd(o_mem_cmd), .o_mem_bank(o_mem_bank),
    .o_mem_strobe(o_mem_strobe), .o_mem_dll_reset(o_mem_dll_reset));
  sdcst_mem_model u_mem (.i_link_clk(i_link_clk), .i_rst(i_rst), .i_cmd(o_mem_cmd),
    .i_bank(o_mem_bank), .i_strobe(o_mem_strobe), .i_dll_reset(o_mem_dll_reset),
    .o_count(m_count), .o_cmd(m_cmd), .o_bank(m_bank), .o_gap(m_gap), .o_dll(m_dll));
  // 4 ns system clock
  initial begin
    i_sys_clk = 1'b0;
    forever #2 i_sys_clk = ~i_sys_clk;
  end
  // 32 ns command clock, offset so the two never line up
  initial begin
    i_link_clk = 1'b0;
    #7.3;
    forever #16 i_link_clk = ~i_link_clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic int cd(input int ps);
    return (ps + TCK - 1) / TCK;
  endfunction : cd
  function automatic int mx(input int a, input int b);
    return (a > b) ? a : b;
  endfunction : mx
  // least gap owed from the previous command to this one
  function automatic int need(input sdcst_cmd_e p, input sdcst_cmd_e c, input logic same,
                              input logic dll, input logic hg, input logic p2);
    int w;
    logic pc, cc;
    w = 1;
    pc = p inside {SDCST_RD, SDCST_WR, SDCST_WRA};
    cc = c inside {SDCST_RD, SDCST_WR, SDCST_WRA};
    if (p == SDCST_MRS) w = (c == SDCST_MRS) ? 4 : mx(12, cd(15000));
    if (p == SDCST_MPR_RD) w = 2;
    if (pc && cc) w = 4;
    if (p inside {SDCST_WR, SDCST_WRA} && c == SDCST_RD) w = WRD + mx(4, cd(7500));
    if (p == SDCST_WRA && c == SDCST_ACT && same) w = WRD + cd(15000) + cd(15000);
    if (p == SDCST_RD && c == SDCST_PRE && same) w = mx(4, cd(7500));
    if (p == SDCST_ACT && c == SDCST_ACT) w = mx(4, cd(p2 ? (hg ? 7500 : 10000)
                                                          : (hg ? 6000 : 7500)));
    if (dll && (cc || c == SDCST_MPR_RD)) w = 512;
    return w;
  endfunction : need
  task automatic wrap_up();
    if (errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  task automatic chk_eq(input logic [2:0] got, input logic [2:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
    end
  endtask : chk_eq
  task automatic chk_min(input logic [10:0] got, input int lo);
    checks++;
    if ($isunknown(got) || got < lo) begin
      errors++;
      $display("unexpected at %0t: gap %0d, wanted at least %0d", $time, got, lo);
    end
  endtask : chk_min
  // offer one command, wait until it reaches the pins, then judge it
  task automatic do_cmd(input sdcst_cmd_e c, input logic [2:0] b, input logic d);
    int n;
    int w;
    logic [15:0] c0;
    c0 = m_count;
    n = 0;
    @(negedge i_sys_clk);
    i_cmd_valid = 1'b1;
    i_cmd = c;
    i_bank = b;
    i_dll_reset = d;
    while (o_cmd_ready !== 1'b1 && n < LIM) begin
      @(negedge i_sys_clk);
      n++;
    end
    @(negedge i_sys_clk);
    i_cmd_valid = 1'b0;
    while (m_count === c0 && n < LIM) begin
      @(negedge i_sys_clk);
      n++;
    end
    if (n >= LIM) begin
      errors++;
      $display("unexpected at %0t: command never reached the pins", $time);
      wrap_up();
    end else begin
      chk_eq(m_cmd, c);
      chk_eq(m_bank, b);
      chk_eq({2'b00, m_dll}, {2'b00, d});
      w = need(p_cmd, c, b == p_bank, p_dll, i_high_grade, i_page_2k);
      chk_min(m_gap, w);
      p_cmd = c;
      p_bank = b;
      p_dll = d;
    end
  endtask : do_cmd
  // hand-picked pairs first, then a seeded random stream
  initial begin
    sdcst_cmd_e cc [16];
    logic [2:0] bb [16];
    cc = '{SDCST_MRS, SDCST_RD, SDCST_WR, SDCST_RD, SDCST_WRA, SDCST_ACT, SDCST_MRS,
           SDCST_MRS, SDCST_RD, SDCST_PRE, SDCST_MPR_RD, SDCST_ACT, SDCST_ACT, SDCST_ACT,
           SDCST_ACT, SDCST_ACT};
    bb = '{3'h0, 3'h0, 3'h1, 3'h1, 3'h2, 3'h2, 3'h0, 3'h0, 3'h3, 3'h3, 3'h0, 3'h4, 3'h5,
           3'h6, 3'h7, 3'h0};
    errors = 0;
    checks = 0;
    seed = 32'h6FD7;
    p_cmd = SDCST_NOP;
    p_bank = 3'h0;
    p_dll = 1'b0;
    i_rst = 1'b1;
    i_cmd_valid = 1'b0;
    i_cmd = SDCST_NOP;
    i_bank = 3'h0;
    i_dll_reset = 1'b0;
    i_high_grade = 1'b0;
    i_page_2k = 1'b0;
    // reset must also span several command clocks, so it is held well past two cycles
    repeat (40) @(negedge i_sys_clk);
    i_rst = 1'b0;
    repeat (32) @(negedge i_sys_clk);
    for (int i = 0; i < 16; i++) do_cmd(cc[i], bb[i], i == 0);
    for (int i = 0; i < 40; i++) begin
      seed = lfsr(seed);
      i_high_grade = seed[6];
      i_page_2k = seed[7];
      do_cmd((seed[2:0] == 3'h0) ? SDCST_RD : sdcst_cmd_e'(seed[2:0]), seed[5:3], 1'b0);
    end
    wrap_up();
  end
endmodule : sdcst_command_spacing_timer_bench

// [sdcst_gap_timer.sv]
`timescale 1ns/1ps
// down counter: after a load of N, busy stays high for N-1 cycles
module sdcst_gap_timer (
  input  wire logic     i_clk,
  input  wire logic     i_rst,
  sdcst_timer_if.timer  tif
);
  import sdcst_pkg::*;

  logic [CW-1:0] cnt;  // cycles left before the gap closes

  // a load of 1 leaves busy low, so the next command may follow at once
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt <= '0;
    end else if (tif.load) begin
      cnt <= tif.value - CW'(1);
    end else if (cnt != '0) begin
      cnt <= cnt - CW'(1);
    end
  end

  assign tif.busy = (cnt != '0);
endmodule : sdcst_gap_timer

// [sdcst_mem_model.sv]
`timescale 1ns/1ps
// memory-side model: latches each strobed command and its spacing in link cycles
module sdcst_mem_model
  import sdcst_pkg::*;
(
  input  wire logic                          i_link_clk,
  input  wire logic                          i_rst,
  input  wire sdcst_pkg::sdcst_cmd_e         i_cmd,
  input  wire logic [sdcst_pkg::BANK_W-1:0]  i_bank,
  input  wire logic                          i_strobe,
  input  wire logic                          i_dll_reset,
  output logic [15:0]                        o_count,
  output sdcst_pkg::sdcst_cmd_e              o_cmd,
  output logic [sdcst_pkg::BANK_W-1:0]       o_bank,
  output logic [10:0]                        o_gap,
  output logic                               o_dll
);
  logic [10:0] since;  // link edges since the last command, saturating
  // latch on the rising command clock, as the device samples its pins
  always_ff @(posedge i_link_clk) begin
    if (i_rst) begin
      o_count <= 16'h0000;
      since   <= 11'h7FF;
      o_gap   <= 11'h000;
    end else if (i_strobe) begin
      o_count <= o_count + 16'h0001;
      o_cmd   <= i_cmd;
      o_bank  <= i_bank;
      o_dll   <= i_dll_reset;
      o_gap   <= since;
      since   <= 11'h001;
    end else if (since != 11'h7FF) begin
      // saturate so a long idle never wraps into a short gap
      since <= since + 11'h001;
    end
  end
endmodule : sdcst_mem_model

// [sdcst_pkg.sv]
package sdcst_pkg;

  // command set offered to the user and driven toward the memory
  typedef enum logic [2:0] {
    SDCST_NOP,
    SDCST_MRS,
    SDCST_ACT,
    SDCST_RD,
    SDCST_WR,
    SDCST_WRA,
    SDCST_PRE,
    SDCST_MPR_RD
  } sdcst_cmd_e;

  localparam int unsigned BANK_W = 3;            // bank address width
  localparam int unsigned NBANK  = 8;            // banks tracked
  localparam int unsigned CW     = 10;           // spacing counter width
  localparam int unsigned NFAW   = 4;            // activates per rolling window

  // cycle minimums, in command clocks
  localparam int unsigned RTP_MIN_CK  = 4;
  localparam int unsigned WTR_MIN_CK  = 4;
  localparam int unsigned MRD_CK      = 4;
  localparam int unsigned MOD_MIN_CK  = 12;
  localparam int unsigned CCD_CK      = 4;
  localparam int unsigned MPRR_CK     = 1;
  localparam int unsigned RRD_MIN_CK  = 4;
  localparam int unsigned DLLK_CK     = 512;

  // time minimums, in picoseconds
  localparam int unsigned T_RTP_PS    = 7500;
  localparam int unsigned T_WTR_PS    = 7500;
  localparam int unsigned T_WR_PS     = 15000;
  localparam int unsigned T_MOD_PS    = 15000;
  localparam int unsigned T_RRD1K_LO  = 7500;    // 1 KB page, lower grade
  localparam int unsigned T_RRD1K_HI  = 6000;    // 1 KB page, higher grade
  localparam int unsigned T_RRD2K_LO  = 10000;
  localparam int unsigned T_RRD2K_HI  = 7500;
  localparam int unsigned T_FAW1K_LO  = 37500;
  localparam int unsigned T_FAW1K_HI  = 30000;
  localparam int unsigned T_FAW2K_LO  = 50000;
  localparam int unsigned T_FAW2K_HI  = 45000;

  // larger of a cycle minimum and a time rounded up to whole cycles
  function automatic int unsigned sdcst_cyc(input int unsigned min_ck,
                                            input int unsigned t_ps,
                                            input int unsigned tck_ps);
    int unsigned c;
    c = (t_ps + tck_ps - 1) / tck_ps;
    return (c > min_ck) ? c : min_ck;
  endfunction : sdcst_cyc

endpackage : sdcst_pkg

// [sdcst_sync.sv]
`timescale 1ns/1ps
// two-flop synchroniser; the first stage feeds only the second
module sdcst_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         i_clk,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] meta;  // metastable stage, read by o_q alone

  // no reset: it also carries the reset itself into the link domain
  always_ff @(posedge i_clk) begin
    meta <= i_d;
    o_q  <= meta;
  end
endmodule : sdcst_sync

// [sdcst_timer_if.sv]
`timescale 1ns/1ps
// one spacing counter: load strobe, spacing in cycles, busy flag
interface sdcst_timer_if;
  import sdcst_pkg::*;
  logic          load;   // start a new gap this cycle
  logic [CW-1:0] value;  // gap length in command clocks, at least 1
  logic          busy;   // gap still running

  modport timer (input load, input value, output busy);
  modport user  (output load, output value, input busy);
endinterface : sdcst_timer_if

// [sdcst_top.sv]
`timescale 1ns/1ps
module sdcst_top #(
  parameter int unsigned TCK_PS     = 1875,   // command clock period in ps
  parameter int unsigned TRP_PS     = 15000,  // precharge period in ps
  parameter int unsigned WR_DATA_CK = 10      // write command to end of data
) (
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_rst,
  input  wire logic                  i_link_clk,
  input  wire logic                  i_cmd_valid,
  input  wire sdcst_pkg::sdcst_cmd_e i_cmd,
  input  wire logic [sdcst_pkg::BANK_W-1:0] i_bank,
  input  wire logic                  i_dll_reset,
  input  wire logic                  i_high_grade,
  input  wire logic                  i_page_2k,
  output logic                       o_cmd_ready,
  output sdcst_pkg::sdcst_cmd_e      o_mem_cmd,
  output logic [sdcst_pkg::BANK_W-1:0] o_mem_bank,
  output logic                       o_mem_strobe,
  output logic                       o_mem_dll_reset
);
  import sdcst_pkg::*;

  // spacing figures in command clocks, ps limits rounded up
  localparam int unsigned C_RTP  = sdcst_cyc(RTP_MIN_CK, T_RTP_PS, TCK_PS);
  localparam int unsigned C_WTR  = WR_DATA_CK
                                 + sdcst_cyc(WTR_MIN_CK, T_WTR_PS, TCK_PS);
  localparam int unsigned C_DAL  = WR_DATA_CK + sdcst_cyc(1, T_WR_PS, TCK_PS)
                                 + sdcst_cyc(1, TRP_PS, TCK_PS);
  localparam int unsigned C_MOD  = sdcst_cyc(MOD_MIN_CK, T_MOD_PS, TCK_PS);
  localparam int unsigned C_R1L  = sdcst_cyc(RRD_MIN_CK, T_RRD1K_LO, TCK_PS);
  localparam int unsigned C_R1H  = sdcst_cyc(RRD_MIN_CK, T_RRD1K_HI, TCK_PS);
  localparam int unsigned C_R2L  = sdcst_cyc(RRD_MIN_CK, T_RRD2K_LO, TCK_PS);
  localparam int unsigned C_R2H  = sdcst_cyc(RRD_MIN_CK, T_RRD2K_HI, TCK_PS);
  localparam int unsigned C_F1L  = sdcst_cyc(1, T_FAW1K_LO, TCK_PS);
  localparam int unsigned C_F1H  = sdcst_cyc(1, T_FAW1K_HI, TCK_PS);
  localparam int unsigned C_F2L  = sdcst_cyc(1, T_FAW2K_LO, TCK_PS);
  localparam int unsigned C_F2H  = sdcst_cyc(1, T_FAW2K_HI, TCK_PS);

  // link-side handshake states
  typedef enum logic {
    SDCST_LS_IDLE,
    SDCST_LS_WAIT
  } sdcst_link_e;

  // pick one of four figures by page size and grade
  function automatic logic [CW-1:0] sdcst_pick(input logic page_2k,
                                               input logic high,
                                               input int unsigned v1l,
                                               input int unsigned v1h,
                                               input int unsigned v2l,
                                               input int unsigned v2h);
    int unsigned v;
    v = page_2k ? (high ? v2h : v2l) : (high ? v1h : v1l);
    return CW'(v);
  endfunction : sdcst_pick

  // ------------------------------------------------------------------
  // system clock side: accept one command, hold it until acknowledged
  // ------------------------------------------------------------------
  logic                  req_tgl;     // flips once per accepted command
  logic                  ack_sync;    // link acknowledge toggle, synchronised
  sdcst_cmd_e            hold_cmd;    // command waiting for the link
  logic [BANK_W-1:0]     hold_bank;   // its bank
  logic                  hold_dll;    // loop reset request with a mode set
  logic                  ack_tgl;     // acknowledge toggle back from the link side
  wire                   take_cmd = o_cmd_ready && i_cmd_valid;
  wire                   ack_done = !o_cmd_ready && (ack_sync == req_tgl);

  sdcst_sync #(.W(1)) u_ack_sync (
    .i_clk (i_sys_clk),
    .i_d   (ack_tgl),
    .o_q   (ack_sync)
  );

  // hold registers stay frozen while a toggle is in flight, so the link
  // may read them directly once it has seen the toggle move
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_cmd_ready <= 1'b1;
      req_tgl     <= 1'b0;
      hold_cmd    <= SDCST_NOP;
      hold_bank   <= '0;
      hold_dll    <= 1'b0;
    end else if (take_cmd) begin
      o_cmd_ready <= 1'b0;
      req_tgl     <= ~req_tgl;
      hold_cmd    <= i_cmd;
      hold_bank   <= i_bank;
      hold_dll    <= i_dll_reset;
    end else if (ack_done) begin
      o_cmd_ready <= 1'b1;            // command went out, take the next
    end
  end

  // ------------------------------------------------------------------
  // link clock side: crossing of reset, configuration and request
  // ------------------------------------------------------------------
  logic        link_rst;    // system reset seen on the link clock
  logic [1:0]  cfg_sync;    // {page_2k, high_grade} on the link clock
  logic        req_sync;    // request toggle on the link clock
  logic        seen;        // last request toggle value taken
  sdcst_link_e state;       // link handshake state
  sdcst_link_e next_state;  // its next value
  logic [1:0]  faw_ptr;     // slot of the oldest activate in the window

  sdcst_sync #(.W(1)) u_rst_sync (
    .i_clk (i_link_clk),
    .i_d   (i_rst),
    .o_q   (link_rst)
  );

  // configuration is quasi-static; a change mid-stream applies to the
  // next gap only, gaps already running keep their length
  sdcst_sync #(.W(2)) u_cfg_sync (
    .i_clk (i_link_clk),
    .i_d   ({i_page_2k, i_high_grade}),
    .o_q   (cfg_sync)
  );

  sdcst_sync #(.W(1)) u_req_sync (
    .i_clk (i_link_clk),
    .i_d   (req_tgl),
    .o_q   (req_sync)
  );

  wire page_2k  = cfg_sync[1];
  wire high_gr  = cfg_sync[0];
  wire new_req  = (req_sync != seen);

  // command classes
  wire is_mrs   = (hold_cmd == SDCST_MRS);
  wire is_act   = (hold_cmd == SDCST_ACT);
  wire is_pre   = (hold_cmd == SDCST_PRE);
  wire is_mpr   = (hold_cmd == SDCST_MPR_RD);
  wire is_rd    = (hold_cmd == SDCST_RD) || is_mpr;
  wire is_wra   = (hold_cmd == SDCST_WRA);
  wire is_wr    = (hold_cmd == SDCST_WR) || is_wra;

  // spacing timers
  sdcst_timer_if t_ccd ();
  sdcst_timer_if t_wtr ();
  sdcst_timer_if t_mrd ();
  sdcst_timer_if t_mod ();
  sdcst_timer_if t_mpr ();
  sdcst_timer_if t_rrd ();
  sdcst_timer_if t_dll ();

  sdcst_gap_timer u_ccd (.i_clk(i_link_clk), .i_rst(link_rst), .tif(t_ccd.timer));
  sdcst_gap_timer u_wtr (.i_clk(i_link_clk), .i_rst(link_rst), .tif(t_wtr.timer));
  sdcst_gap_timer u_mrd (.i_clk(i_link_clk), .i_rst(link_rst), .tif(t_mrd.timer));
  sdcst_gap_timer u_mod (.i_clk(i_link_clk), .i_rst(link_rst), .tif(t_mod.timer));
  sdcst_gap_timer u_mpr (.i_clk(i_link_clk), .i_rst(link_rst), .tif(t_mpr.timer));
  sdcst_gap_timer u_rrd (.i_clk(i_link_clk), .i_rst(link_rst), .tif(t_rrd.timer));
  sdcst_gap_timer u_dll (.i_clk(i_link_clk), .i_rst(link_rst), .tif(t_dll.timer));

  logic [NBANK-1:0] rtp_busy;   // per bank read to precharge gap
  logic [NBANK-1:0] dal_busy;   // per bank auto-precharge write gap
  logic [NFAW-1:0]  faw_busy;   // per slot rolling activate window
  logic             allowed;    // held command may go out now
  wire              issue = (state == SDCST_LS_WAIT) && allowed;

  // per bank gaps, one pair of counters each
  for (genvar b = 0; b < NBANK; b++) begin : g_bank
    sdcst_timer_if t_rtp ();
    sdcst_timer_if t_dal ();
    wire hit = (hold_bank == BANK_W'(b));
    sdcst_gap_timer u_rtp (.i_clk(i_link_clk), .i_rst(link_rst), .tif(t_rtp.timer));
    sdcst_gap_timer u_dal (.i_clk(i_link_clk), .i_rst(link_rst), .tif(t_dal.timer));
    assign t_rtp.load  = issue && is_rd && hit;
    assign t_rtp.value = CW'(C_RTP);
    assign t_dal.load  = issue && is_wra && hit;
    assign t_dal.value = CW'(C_DAL);
    assign rtp_busy[b] = t_rtp.busy;
    assign dal_busy[b] = t_dal.busy;
  end

  // four window slots, filled round robin by each activate
  for (genvar f = 0; f < NFAW; f++) begin : g_faw
    sdcst_timer_if t_faw ();
    sdcst_gap_timer u_faw (.i_clk(i_link_clk), .i_rst(link_rst), .tif(t_faw.timer));
    assign t_faw.load  = issue && is_act && (faw_ptr == 2'(f));
    assign t_faw.value = sdcst_pick(page_2k, high_gr, C_F1L, C_F1H, C_F2L, C_F2H);
    assign faw_busy[f] = t_faw.busy;
  end

  // gap loads on the edge that drives the command out
  assign t_ccd.load  = issue && (is_rd || is_wr);
  assign t_ccd.value = CW'(CCD_CK);
  assign t_wtr.load  = issue && is_wr;
  assign t_wtr.value = CW'(C_WTR);
  assign t_mrd.load  = issue && is_mrs;
  assign t_mrd.value = CW'(MRD_CK);
  assign t_mod.load  = issue && is_mrs;
  assign t_mod.value = CW'(C_MOD);
  assign t_mpr.load  = issue && is_mpr;
  assign t_mpr.value = CW'(MPRR_CK + 1);
  assign t_rrd.load  = issue && is_act;
  assign t_rrd.value = sdcst_pick(page_2k, high_gr, C_R1L, C_R1H, C_R2L, C_R2H);
  assign t_dll.load  = issue && is_mrs && hold_dll;
  assign t_dll.value = CW'(DLLK_CK);

  // gate common to every command: register read recovery, and the mode
  // set gaps, where a second mode set needs only the shorter one
  wire ok_common = !t_mpr.busy
                 && (is_mrs ? !t_mrd.busy : !t_mod.busy);

  // per command gate
  always_comb begin
    allowed = 1'b0;
    case (hold_cmd)
      SDCST_RD, SDCST_MPR_RD: begin
        allowed = !t_ccd.busy && !t_wtr.busy && !t_dll.busy;
      end
      SDCST_WR, SDCST_WRA: begin
        allowed = !t_ccd.busy && !t_dll.busy;
      end
      SDCST_PRE: begin
        allowed = !rtp_busy[hold_bank];
      end
      SDCST_ACT: begin
        // oldest slot still running means a fifth activate too soon
        allowed = !t_rrd.busy && !faw_busy[faw_ptr]
                  && !dal_busy[hold_bank];
      end
      SDCST_MRS: begin
        allowed = 1'b1;
      end
      default: begin
        allowed = 1'b1;                                              // no-op waits only on the common gate
      end
    endcase
    allowed = allowed && ok_common;
  end

  // handshake state: idle until a new toggle, wait until the gaps open
  always_comb begin
    next_state = state;
    case (state)
      SDCST_LS_IDLE: begin
        if (new_req) begin
          next_state = SDCST_LS_WAIT;
        end
      end
      SDCST_LS_WAIT: begin
        if (issue) begin
          next_state = SDCST_LS_IDLE;
        end
      end
      default: begin
        next_state = SDCST_LS_IDLE;
      end
    endcase
  end

  // handshake bookkeeping on the link clock
  always_ff @(posedge i_link_clk) begin
    if (link_rst) begin
      state   <= SDCST_LS_IDLE;
      seen    <= 1'b0;
      ack_tgl <= 1'b0;
      faw_ptr <= '0;
    end else begin
      state <= next_state;
      if (state == SDCST_LS_IDLE && new_req) begin
        seen <= req_sync;                 // hold regs stable from here on
      end
      if (issue) begin
        ack_tgl <= seen;                  // release the system side
      end
      if (issue && is_act) begin
        faw_ptr <= faw_ptr + 2'(1);       // advance to the next oldest slot
      end
    end
  end

  // command pins: one strobe cycle per command, no-op otherwise
  always_ff @(posedge i_link_clk) begin
    if (link_rst) begin
      o_mem_strobe    <= 1'b0;
      o_mem_cmd       <= SDCST_NOP;
      o_mem_bank      <= '0;
      o_mem_dll_reset <= 1'b0;
    end else begin
      o_mem_strobe    <= issue;
      o_mem_cmd       <= issue ? hold_cmd : SDCST_NOP;
      o_mem_bank      <= issue ? hold_bank : '0;
      o_mem_dll_reset <= issue && is_mrs && hold_dll;
    end
  end

endmodule : sdcst_top

// [sdcst_top_assertions.sv]
`timescale 1ns/1ps
// spacing checks on the memory pins, measured in command clocks
module sdcst_top_checker
  import sdcst_pkg::*;
#(
  parameter int unsigned TCK_PS     = 1875,
  parameter int unsigned TRP_PS     = 15000,
  parameter int unsigned WR_DATA_CK = 10
) (
  input wire logic                          i_sys_clk,
  input wire logic                          i_rst,
  input wire logic                          i_link_clk,
  input wire logic                          i_cmd_valid,
  input wire logic                          i_high_grade,
  input wire logic                          i_page_2k,
  input wire logic                          o_cmd_ready,
  input wire sdcst_pkg::sdcst_cmd_e         o_mem_cmd,
  input wire logic [sdcst_pkg::BANK_W-1:0]  o_mem_bank,
  input wire logic                          o_mem_strobe,
  input wire logic                          o_mem_dll_reset
);
  function automatic int unsigned cd(input int unsigned ps);
    return (ps + TCK_PS - 1) / TCK_PS;
  endfunction : cd
  function automatic int unsigned mx(input int unsigned a, input int unsigned b);
    return (a > b) ? a : b;
  endfunction : mx
  localparam int unsigned N_RTP = mx(RTP_MIN_CK, cd(T_RTP_PS));
  localparam int unsigned N_WTR = WR_DATA_CK + mx(WTR_MIN_CK, cd(T_WTR_PS));
  localparam int unsigned N_DAL = WR_DATA_CK + cd(T_WR_PS) + cd(TRP_PS);
  localparam int unsigned N_MOD = mx(MOD_MIN_CK, cd(T_MOD_PS));
  localparam int unsigned N_R1L = mx(RRD_MIN_CK, cd(T_RRD1K_LO));
  localparam int unsigned N_R1H = mx(RRD_MIN_CK, cd(T_RRD1K_HI));
  localparam int unsigned N_R2L = mx(RRD_MIN_CK, cd(T_RRD2K_LO));
  localparam int unsigned N_R2H = mx(RRD_MIN_CK, cd(T_RRD2K_HI));
  logic [7:0]  hit;       // one flag per tracked command class
  logic [10:0] cnt [8];   // link edges since each class, saturating
  logic [2:0]  rd_bank;   // bank of the latest read
  logic [2:0]  wra_bank;  // bank of the latest auto-precharge write
  logic [10:0] rrd_need;  // activate spacing for the current grade and page
  assign hit[0] = o_mem_strobe && (o_mem_cmd == SDCST_MRS);
  assign hit[1] = o_mem_strobe && (o_mem_cmd inside {SDCST_WR, SDCST_WRA});
  assign hit[2] = o_mem_strobe && (o_mem_cmd == SDCST_RD);
  assign hit[3] = o_mem_strobe && (o_mem_cmd == SDCST_WRA);
  assign hit[4] = o_mem_strobe && (o_mem_cmd inside {SDCST_RD, SDCST_WR, SDCST_WRA});
  assign hit[5] = o_mem_strobe && (o_mem_cmd == SDCST_MPR_RD);
  assign hit[6] = o_mem_strobe && (o_mem_cmd == SDCST_ACT);
  assign hit[7] = o_mem_strobe && o_mem_dll_reset;
  assign rrd_need = i_page_2k ? 11'(i_high_grade ? N_R2H : N_R2L)
                              : 11'(i_high_grade ? N_R1H : N_R1L);
  // counters start saturated so nothing is owed right after reset
  always_ff @(posedge i_link_clk) begin
    for (int k = 0; k < 8; k++) begin
      if (i_rst) cnt[k] <= 11'h7FF;
      else if (hit[k]) cnt[k] <= 11'h001;
      else if (cnt[k] != 11'h7FF) cnt[k] <= cnt[k] + 11'h001;
    end
  end
  // banks kept only for the same-bank gaps
  always_ff @(posedge i_link_clk) begin
    if (hit[2]) rd_bank <= o_mem_bank;
    if (hit[3]) wra_bank <= o_mem_bank;
  end
  sequence s_issue(sdcst_cmd_e k);
    o_mem_strobe && (o_mem_cmd == k);
  endsequence
  sequence s_take;
    i_cmd_valid && o_cmd_ready;
  endsequence
  a_take_drops_ready: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    s_take |=> !o_cmd_ready [*4]) else $error("ready did not drop after a take");
  a_strobe_one_cycle: assert property (@(posedge i_link_clk) disable iff (i_rst)
    $rose(o_mem_strobe) |=> !o_mem_strobe) else $error("strobe longer than one cycle");
  a_idle_pins_quiet: assert property (@(posedge i_link_clk) disable iff (i_rst)
    !o_mem_strobe |-> o_mem_cmd == SDCST_NOP && o_mem_bank == 3'h0 && !o_mem_dll_reset)
    else $error("pins not idle without strobe");
  a_rd_to_pre: assert property (@(posedge i_link_clk) disable iff (i_rst)
    s_issue(SDCST_PRE) ##0 (o_mem_bank == rd_bank) |-> cnt[2] >= N_RTP)
    else $error("read to precharge too close");
  a_wr_to_rd: assert property (@(posedge i_link_clk) disable iff (i_rst)
    s_issue(SDCST_RD) |-> cnt[1] >= N_WTR) else $error("write to read too close");
  a_wra_to_act: assert property (@(posedge i_link_clk) disable iff (i_rst)
    s_issue(SDCST_ACT) ##0 (o_mem_bank == wra_bank) |-> cnt[3] >= N_DAL)
    else $error("auto precharge write to activate too close");
  a_mrs_to_mrs: assert property (@(posedge i_link_clk) disable iff (i_rst)
    s_issue(SDCST_MRS) |-> cnt[0] >= MRD_CK) else $error("mode sets too close");
  a_mrs_update: assert property (@(posedge i_link_clk) disable iff (i_rst)
    o_mem_strobe && o_mem_cmd != SDCST_MRS |-> cnt[0] >= N_MOD)
    else $error("command too soon after mode set");
  a_col_to_col: assert property (@(posedge i_link_clk) disable iff (i_rst)
    hit[4] |-> cnt[4] >= CCD_CK) else $error("column commands too close");
  a_mpr_recover: assert property (@(posedge i_link_clk) disable iff (i_rst)
    o_mem_strobe |-> cnt[5] >= MPRR_CK + 1) else $error("no recovery after register read");
  a_act_to_act: assert property (@(posedge i_link_clk) disable iff (i_rst)
    s_issue(SDCST_ACT) |-> cnt[6] >= rrd_need) else $error("activates too close");
  a_dll_lock_wait: assert property (@(posedge i_link_clk) disable iff (i_rst)
    hit[4] || hit[5] |-> cnt[7] >= DLLK_CK) else $error("access before loop lock");
  a_dll_with_mrs: assert property (@(posedge i_link_clk) disable iff (i_rst)
    o_mem_dll_reset |-> s_issue(SDCST_MRS)) else $error("loop reset without mode set");
endmodule : sdcst_top_checker

bind sdcst_top sdcst_top_checker #(.TCK_PS(TCK_PS), .TRP_PS(TRP_PS), .WR_DATA_CK(WR_DATA_CK))
  u_chk (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_link_clk(i_link_clk),
  .i_cmd_valid(i_cmd_valid), .i_high_grade(i_high_grade), .i_page_2k(i_page_2k),
  .o_cmd_ready(o_cmd_ready), .o_mem_cmd(o_mem_cmd), .o_mem_bank(o_mem_bank),
  .o_mem_strobe(o_mem_strobe), .o_mem_dll_reset(o_mem_dll_reset));
